// [wd_consts.svh]
`ifndef WD_CONSTS_SVH
`define WD_CONSTS_SVH

// register indices; byte address is four times the index
`define SERVICE_IDX       32'h0000FFFF
`define CONFIG_IDX        32'h0000001F
`define CAUSE_IDX         32'h00000020
`define SERVICE_ADDR      (`SERVICE_IDX << 2)
`define CONFIG_ADDR       (`CONFIG_IDX << 2)
`define CAUSE_ADDR        (`CAUSE_IDX << 2)

// bus encodings
`define HSIZE_WORD        3'h2
`define HRESP_OKAY        1'b0

// configuration reset value and bits kept over a non-power-on reset
`define CFG_RESET         8'h00
`define CFG_KEEP_MASK     8'h08

// cause/status register field positions
`define CAUSE_WD_BIT      0
`define CAUSE_STOP_BIT    1
`define CAUSE_RUN_BIT     2
`define CAUSE_CNT_LSB     8
`define CAUSE_PRE_LSB     16

// counter geometry
`define PRE_W             12
`define WD_W              6
`define PRE_KEEP_W        4
`define SHORT_TAP         6
`define PRE_SERVICE_MASK  12'h00F

// timing counts in fast-clock cycles
`define RST_PULSE_CYCLES  6'd32
`define REC_SHORT_CYCLES  13'd32
`define REC_LONG_CYCLES   13'd4096
`define POR_CYCLES        13'd4096

`endif

// [wd_pkg.sv]
package wd_pkg;

	typedef enum logic [1:0] {BUS_IDLE, BUS_WAIT, BUS_DONE} bus_phase_e;

	typedef enum logic [1:0] {ST_RUN, ST_STOPPED, ST_RECOVER} stop_state_e;

	typedef struct packed {
		logic watchdog_rate_select;
		logic low_voltage_guard_stop;
		logic low_voltage_guard_rst_off;
		logic low_voltage_guard_pwr_off;
		logic low_voltage_guard_trip;
		logic short_recovery_select;
		logic stop_enable;
		logic watchdog_disable;
	} sys_config_one_s;

	typedef struct packed {
		logic monitor_mode;
		logic break_active;
		logic break_watchdog_disable;
	} debug_mode_s;

	typedef struct packed {
		logic        write;
		logic        word;
		logic [31:0] addr;
	} bus_req_s;

endpackage

// [cop_watchdog_timer.sv]
// The implementer's own choice: the AHB-Lite register port.
`include "wd_consts.svh"
`timescale 1ns/1ps

module cop_watchdog_timer
	import wd_pkg::*;
(
	input  logic        mclk,
	input  logic        rstn,
	input  logic        hsel,
	input  logic [31:0] haddr,
	input  logic [1:0]  htrans,
	input  logic        hwrite,
	input  logic [2:0]  hsize,
	input  logic [31:0] hwdata,
	input  logic        hready,
	output logic        hreadyout,
	output logic        hresp,
	output logic [31:0] hrdata,
	input  logic [7:0]  reset_vector_lo,
	input  logic        reset_pin_enable,
	input  logic        int_reset,
	input  debug_mode_s debug_mode,
	input  logic        test_high_voltage,
	input  logic        stop_exec,
	input  logic        wake_req,
	input  logic        low_voltage_wake,
	output logic        stop_mode,
	output logic        stop_exit,
	output logic        illegal_opcode,
	output logic        sys_reset,
	output logic        rst_pin_out,
	output logic        rst_pin_oe
);

	bus_phase_e         phase_reg;
	bus_req_s           req_reg;
	logic [31:0]        hrdata_reg;
	logic [31:0]        rd_next;
	sys_config_one_s    cfg_reg;
	logic               cfg_lock_reg;
	logic               cause_reg;
	logic               tst_meta_reg;
	logic               tst_sync_reg;
	logic [`PRE_W-1:0]  pre_reg;
	logic [`WD_W-1:0]   wd_cnt_reg;
	logic [12:0]        por_cnt_reg;
	logic               por_done_reg;
	stop_state_e        stop_state_reg;
	logic [12:0]        rec_cnt_reg;
	logic               stop_exit_reg;
	logic               illegal_reg;
	logic               sys_reset_reg;
	logic [5:0]         rst_cnt_reg;
	logic               rst_pin_oe_reg;
	logic               addr_take;
	logic               do_write;
	logic               wr_service;
	logic               wr_config;
	logic               rd_cause;
	logic               reset_any;
	logic               frozen;
	logic               stop_enter;
	logic               por_clear;
	logic               wd_run;
	logic               wd_tick;
	logic               tap_hit;
	logic               timeout;
	// ---------------- bus slave ----------------
	// one wait state: the access is carried out in the first data-phase
	// cycle, so a read right after a write sees the written value
	assign addr_take = hsel && htrans[1] && hready;
	assign hreadyout = (phase_reg != BUS_WAIT);
	assign hresp     = `HRESP_OKAY;
	assign hrdata    = hrdata_reg;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			phase_reg <= BUS_IDLE;
		end else begin
			case (phase_reg)
				BUS_IDLE: begin
					if (addr_take) begin
						phase_reg <= BUS_WAIT;
					end
				end
				BUS_WAIT: begin
					phase_reg <= BUS_DONE;
				end
				BUS_DONE: begin
					if (addr_take) begin
						phase_reg <= BUS_WAIT;
					end else begin
						phase_reg <= BUS_IDLE;
					end
				end
				default: begin
					phase_reg <= BUS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			req_reg <= '0;
		end else if (addr_take) begin
			req_reg.write <= hwrite;
			req_reg.word  <= (hsize == `HSIZE_WORD);
			req_reg.addr  <= haddr;
		end
	end

	// only whole-word writes take effect; others complete silently
	assign do_write   = (phase_reg == BUS_WAIT) && req_reg.write
		&& req_reg.word;
	assign wr_service = do_write && (req_reg.addr == `SERVICE_ADDR);
	assign wr_config  = do_write && (req_reg.addr == `CONFIG_ADDR);
	assign rd_cause   = (phase_reg == BUS_WAIT) && !req_reg.write
		&& (req_reg.addr == `CAUSE_ADDR);

	always_comb begin
		rd_next = '0;
		case (req_reg.addr)
			`SERVICE_ADDR: begin
				rd_next[7:0] = reset_vector_lo;
			end
			`CONFIG_ADDR: begin
				rd_next[7:0] = cfg_reg;
			end
			`CAUSE_ADDR: begin
				rd_next[`CAUSE_WD_BIT]   = cause_reg;
				rd_next[`CAUSE_STOP_BIT] = frozen;
				rd_next[`CAUSE_RUN_BIT]  = wd_run;
				rd_next[`CAUSE_CNT_LSB +: `WD_W] = wd_cnt_reg;
				rd_next[`CAUSE_PRE_LSB +: `PRE_W] = pre_reg;
			end
			default: begin
				rd_next = '0;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			hrdata_reg <= '0;
		end else if ((phase_reg == BUS_WAIT) && !req_reg.write) begin
			hrdata_reg <= rd_next;
		end
	end
	// ---------------- configuration ----------------
	assign reset_any = int_reset || sys_reset_reg;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cfg_reg      <= `CFG_RESET;
			cfg_lock_reg <= 1'b0;
		end else if (reset_any) begin
			cfg_reg      <= cfg_reg & `CFG_KEEP_MASK;
			cfg_lock_reg <= 1'b0;
		end else if (wr_config && !cfg_lock_reg) begin
			cfg_reg      <= hwdata[7:0];
			cfg_lock_reg <= 1'b1;
		end
	end
	// sticky cause; a timeout in the reading cycle survives the clear
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cause_reg <= 1'b0;
		end else if (timeout) begin
			cause_reg <= 1'b1;
		end else if (rd_cause) begin
			cause_reg <= 1'b0;
		end
	end
	// ---------------- enable gating ----------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			tst_meta_reg <= 1'b0;
			tst_sync_reg <= 1'b0;
		end else begin
			tst_meta_reg <= test_high_voltage;
			tst_sync_reg <= tst_meta_reg;
		end
	end

	// wait mode has no input here: counting never depends on it
	assign wd_run = !cfg_reg.watchdog_disable
		&& !(debug_mode.monitor_mode && tst_sync_reg)
		&& !(debug_mode.monitor_mode && debug_mode.break_active
		&& debug_mode.break_watchdog_disable);
	// ---------------- stop mode ----------------
	assign frozen     = (stop_state_reg != ST_RUN);
	assign stop_mode  = frozen;
	assign stop_enter = (stop_state_reg == ST_RUN) && stop_exec
		&& cfg_reg.stop_enable && !reset_any;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			stop_state_reg <= ST_RUN;
			rec_cnt_reg    <= '0;
		end else if (reset_any) begin
			stop_state_reg <= ST_RUN;
			rec_cnt_reg    <= '0;
		end else begin
			case (stop_state_reg)
				ST_RUN: begin
					if (stop_enter) begin
						stop_state_reg <= ST_STOPPED;
					end
				end
				ST_STOPPED: begin
					if (low_voltage_wake) begin
						stop_state_reg <= ST_RECOVER;
						rec_cnt_reg <= `REC_LONG_CYCLES - 13'd1;
					end else if (wake_req) begin
						stop_state_reg <= ST_RECOVER;
						rec_cnt_reg <= cfg_reg.short_recovery_select
							? `REC_SHORT_CYCLES - 13'd1
							: `REC_LONG_CYCLES - 13'd1;
					end
				end
				ST_RECOVER: begin
					if (rec_cnt_reg == 13'd0) begin
						stop_state_reg <= ST_RUN;
					end else begin
						rec_cnt_reg <= rec_cnt_reg - 13'd1;
					end
				end
				default: begin
					stop_state_reg <= ST_RUN;
				end
			endcase
		end
	end
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			stop_exit_reg <= 1'b0;
			illegal_reg   <= 1'b0;
		end else begin
			stop_exit_reg <= !reset_any && (stop_state_reg == ST_RECOVER)
				&& (rec_cnt_reg == 13'd0);
			illegal_reg   <= !reset_any && (stop_state_reg == ST_RUN)
				&& stop_exec && !cfg_reg.stop_enable;
		end
	end
	assign stop_exit      = stop_exit_reg;
	assign illegal_opcode = illegal_reg;
	// ---------------- power-on clear ----------------
	assign por_clear = !por_done_reg && (por_cnt_reg == `POR_CYCLES - 13'd1);
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			por_cnt_reg  <= '0;
			por_done_reg <= 1'b0;
		end else if (!por_done_reg) begin
			por_cnt_reg  <= por_cnt_reg + 13'd1;
			por_done_reg <= por_clear;
		end
	end
	// ---------------- prescaler and watchdog counter ----------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pre_reg <= '0;
		end else if (reset_any || por_clear || stop_enter) begin
			pre_reg <= '0;
		end else if (wr_service) begin
			pre_reg <= pre_reg & `PRE_SERVICE_MASK;
		end else if (!frozen) begin
			pre_reg <= pre_reg + 12'd1;
		end
	end

	// short period steps on the low seven stages, long on all twelve
	assign wd_tick = cfg_reg.watchdog_rate_select
		? (&pre_reg[`SHORT_TAP:0]) : (&pre_reg);
	// the final step is cut 16 cycles short since service leaves the
	// low four stages running; this gives 8161 to 8176 and 262,113 to 262,128
	assign tap_hit = (pre_reg[`PRE_KEEP_W-1:0] == '0)
		&& (cfg_reg.watchdog_rate_select
		? (&pre_reg[`SHORT_TAP:`PRE_KEEP_W])
		: (&pre_reg[`PRE_W-1:`PRE_KEEP_W]));
	assign timeout = wd_run && !frozen && !reset_any && !wr_service
		&& (&wd_cnt_reg) && tap_hit;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			wd_cnt_reg <= '0;
		end else if (reset_any || wr_service) begin
			wd_cnt_reg <= '0;
		end else if (!frozen && !stop_enter && wd_run && wd_tick) begin
			wd_cnt_reg <= wd_cnt_reg + 6'd1;
		end
	end
	// ---------------- reset generation ----------------
	// the reset output is the only action; no interrupt exists here
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sys_reset_reg  <= 1'b0;
			rst_cnt_reg    <= '0;
			rst_pin_oe_reg <= 1'b0;
		end else if (timeout) begin
			sys_reset_reg  <= 1'b1;
			rst_cnt_reg    <= `RST_PULSE_CYCLES - 6'd1;
			rst_pin_oe_reg <= reset_pin_enable;
		end else if (sys_reset_reg) begin
			if (rst_cnt_reg == 6'd0) begin
				sys_reset_reg  <= 1'b0;
				rst_pin_oe_reg <= 1'b0;
			end else begin
				rst_cnt_reg <= rst_cnt_reg - 6'd1;
			end
		end
	end
	assign sys_reset   = sys_reset_reg;
	assign rst_pin_out = 1'b0;
	assign rst_pin_oe  = rst_pin_oe_reg;

	// ---------------- assertions ----------------
	a_service_clears_cnt:
	assert property (@(posedge mclk) disable iff (!rstn)
		wr_service |=> (wd_cnt_reg == '0)
		&& (pre_reg[`PRE_W-1:`PRE_KEEP_W] == '0))
	else $error("service did not clear counters");
	a_reset_pulse_len:
	assert property (@(posedge mclk) disable iff (!rstn)
		$fell(sys_reset_reg) |-> $past(timeout, 33))
	else $error("reset pulse not 32 cycles");
	a_reset_pulse_held:
	assert property (@(posedge mclk) disable iff (!rstn)
		timeout |=> sys_reset_reg [*8])
	else $error("reset pulse ended early");
	a_pin_follows_en:
	assert property (@(posedge mclk) disable iff (!rstn)
		timeout |=> (rst_pin_oe_reg == $past(reset_pin_enable)) && cause_reg)
	else $error("pin drive or cause wrong after timeout");
	a_disabled_no_reset:
	assert property (@(posedge mclk) disable iff (!rstn)
		(cfg_reg.watchdog_disable || frozen)
		|-> !timeout ##1 !$rose(sys_reset_reg))
	else $error("timeout while disabled or stopped");
	a_monitor_hv_off:
	assert property (@(posedge mclk) disable iff (!rstn)
		(debug_mode.monitor_mode && tst_sync_reg)
		|-> !wd_run ##1 !$rose(sys_reset_reg))
	else $error("watchdog runs in monitor mode with high voltage");
	a_illegal_stop:
	assert property (@(posedge mclk) disable iff (!rstn)
		(stop_state_reg == ST_RUN && stop_exec && !cfg_reg.stop_enable
		&& !reset_any) |=> illegal_reg && (stop_state_reg == ST_RUN))
	else $error("stop with stop disabled not refused");
	a_stop_clears_pre:
	assert property (@(posedge mclk) disable iff (!rstn)
		stop_enter |=> (pre_reg == '0) && (wd_cnt_reg
		== ($past(wr_service) ? 6'h00 : $past(wd_cnt_reg))))
	else $error("stop entry did not clear prescaler");
	a_short_recovery:
	assert property (@(posedge mclk) disable iff (!rstn || reset_any)
		(stop_state_reg == ST_STOPPED && wake_req && !low_voltage_wake
		&& cfg_reg.short_recovery_select)
		|=> ##31 (stop_state_reg == ST_RECOVER) ##1 (stop_state_reg == ST_RUN))
	else $error("short recovery not 32 cycles");
	a_lv_long_recovery:
	assert property (@(posedge mclk) disable iff (!rstn)
		(stop_state_reg == ST_STOPPED && low_voltage_wake && !reset_any)
		|=> rec_cnt_reg == `REC_LONG_CYCLES - 13'd1)
	else $error("low-voltage exit did not use long recovery");
	a_config_once:
	assert property (@(posedge mclk) disable iff (!rstn)
		(wr_config && cfg_lock_reg && !reset_any) |=> $stable(cfg_reg))
	else $error("locked configuration changed");
	a_por_clear_pre:
	assert property (@(posedge mclk) disable iff (!rstn)
		por_clear |=> (pre_reg == '0) && por_done_reg)
	else $error("power-on clear missing");
	a_internal_reset:
	assert property (@(posedge mclk) disable iff (!rstn)
		int_reset |=> (pre_reg == '0) && (wd_cnt_reg == '0))
	else $error("internal reset did not clear counters");

endmodule

// [tb_top.sv]
`timescale 1ns/1ps
`include "wd_consts.svh"
module tb_top
	import wd_pkg::*;
	;
	logic        mclk, rstn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [7:0]  vec;
	logic        rpe, int_reset, thv, stop_exec, wake_req, lvw;
	debug_mode_s dbg;
	logic        stop_mode, stop_exit, ill, sys_reset, rpo, rpoe;
	int          errors, total_checks, cyc, rst_seen, n, k, m;

	assign hready = hreadyout;

	cop_watchdog_timer i_cop_watchdog_timer (
		.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .reset_vector_lo(vec), .reset_pin_enable(rpe),
		.int_reset(int_reset), .debug_mode(dbg), .test_high_voltage(thv),
		.stop_exec(stop_exec), .wake_req(wake_req),
		.low_voltage_wake(lvw), .stop_mode(stop_mode),
		.stop_exit(stop_exit), .illegal_opcode(ill),
		.sys_reset(sys_reset), .rst_pin_out(rpo), .rst_pin_oe(rpoe));

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	task end_of_test;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// whole run is near 70k cycles; a hang ends well before a second run
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 100000) begin
			errors++;
			$display("BAD %0t run hangs", $time);
			end_of_test();
		end
	end

	always @(negedge mclk) if (sys_reset === 1'b1) rst_seen++;

	task chk(input logic ok, input string msg);
		total_checks++;
		if (ok !== 1'b1) begin
			errors++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask

	task cycles(input int c);
		repeat (c) @(posedge mclk);
	endtask

	function automatic int exp_recovery(input logic sh, input logic lv);
		return (sh && !lv) ? 32 : 4096;
	endfunction

	function automatic int exp_timeout(input logic rate);
		return rate ? 8176 : 262128;
	endfunction

	// called just after a rising edge; ready is judged on the falling edge
	// before each sampling edge so the phase register update cannot race
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		logic ok;
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		hsize <= `HSIZE_WORD;
		do begin
			@(negedge mclk);
			ok = hreadyout;
			@(posedge mclk);
		end while (ok !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do begin
			@(negedge mclk);
			ok = hreadyout;
			rd = hrdata;
			@(posedge mclk);
		end while (ok !== 1'b1);
	endtask

	task reinit(input logic [7:0] c);
		int_reset <= 1'b1;
		@(posedge mclk);
		int_reset <= 1'b0;
		@(posedge mclk);
		bus(1'b1, `CONFIG_ADDR, {24'h0, c});
		bus(1'b1, `SERVICE_ADDR, $urandom);
		rst_seen = 0;
	endtask

	task quiet(input string msg);
		cycles(8500);
		chk(rst_seen == 0, msg);
	endtask

	task stop_cycle(input logic sh, input logic lv, input int w);
		stop_exec <= 1'b1;
		@(posedge mclk);
		stop_exec <= 1'b0;
		@(negedge mclk);
		chk(stop_mode === 1'b1, "stop entry");
		@(posedge mclk);
		bus(1'b0, `CAUSE_ADDR, 32'h0);
		chk(rd[27:16] === 12'h000, "prescaler left running");
		cycles(w);
		wake_req <= 1'b1;
		lvw <= lv;
		@(posedge mclk);
		wake_req <= 1'b0;
		lvw <= 1'b0;
		n = 0;
		do begin
			@(negedge mclk);
			if (stop_exit !== 1'b1)
				n++;
		end while (stop_exit !== 1'b1 && n < 5000);
		chk(n == exp_recovery(sh, lv), "recovery length");
		@(posedge mclk);
		bus(1'b1, `SERVICE_ADDR, $urandom);
	endtask

	initial begin
		{hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
		{int_reset, thv, stop_exec, wake_req, lvw} = '0;
		dbg = '0;
		rstn = 1'b0;
		cyc = 0;
		errors = 0;
		total_checks = 0;
		rst_seen = 0;
		void'($urandom(70035));
		vec = $urandom;
		rpe = $urandom;
		repeat (5) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		bus(1'b0, `CONFIG_ADDR, 32'h0);
		chk(rd === 32'h0, "config reset value");
		bus(1'b0, `SERVICE_ADDR, 32'h0);
		chk(rd === {24'h0, vec}, "service read value");
		bus(1'b0, 32'h0000_0100, 32'h0);
		chk(rd === 32'h0 && hresp === 1'b0, "unmapped read");
		bus(1'b1, `CONFIG_ADDR, 32'h86);
		bus(1'b1, `CONFIG_ADDR, 32'h01);
		bus(1'b0, `CONFIG_ADDR, 32'h0);
		chk(rd[7:0] === 8'h86, "second config write taken");
		$display("test map done");

		// clear of the power-on prescaler lies behind us
		cycles(4200);
		bus(1'b1, `SERVICE_ADDR, $urandom);
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (sys_reset !== 1'b1 && n < 9000);
		k = exp_timeout(1'b1);
		chk(n >= k - 18 && n <= k + 4, "fast timeout length");
		k = 0;
		m = 0;
		while (sys_reset === 1'b1 && k < 100) begin
			k++;
			if (rpoe !== rpe || rpo !== 1'b0)
				m++;
			@(negedge mclk);
		end
		chk(k == 32, "reset pulse length");
		chk(m == 0, "reset pin drive");
		@(posedge mclk);
		bus(1'b0, `CAUSE_ADDR, 32'h0);
		chk(rd[0] === 1'b1, "cause bit missing");
		bus(1'b0, `CAUSE_ADDR, 32'h0);
		chk(rd[0] === 1'b0, "cause bit kept after read");
		bus(1'b0, `CONFIG_ADDR, 32'h0);
		chk(rd[7:0] === 8'h00, "config after timeout");
		$display("test timeout done");

		reinit(8'h80);
		repeat (3) begin
			cycles($urandom_range(6500, 200));
			bus(1'b1, `SERVICE_ADDR, $urandom);
		end
		chk(rst_seen == 0, "serviced watchdog fired");
		int_reset <= 1'b1;
		@(posedge mclk);
		int_reset <= 1'b0;
		@(posedge mclk);
		bus(1'b0, `CAUSE_ADDR, 32'h0);
		chk({rd[27:20], rd[13:8]} === 14'h0000, "int reset");
		bus(1'b1, `CONFIG_ADDR, 32'h00);
		bus(1'b1, `SERVICE_ADDR, $urandom);
		cycles(5000);
		bus(1'b0, `CAUSE_ADDR, 32'h0);
		chk(rd[13:8] === 6'h01, "slow rate step");
		$display("test service done");

		reinit(8'h81);
		quiet("disabled watchdog fired");
		dbg <= '{1'b1, 1'b0, 1'b0};
		reinit(8'h80);
		bus(1'b0, `CAUSE_ADDR, 32'h0);
		chk(rd[2] === 1'b1, "monitor alone stopped watchdog");
		thv <= 1'b1;
		reinit(8'h80);
		quiet("monitor watchdog fired");
		thv <= 1'b0;
		dbg <= '{1'b1, 1'b1, 1'b1};
		reinit(8'h80);
		quiet("break watchdog fired");
		dbg <= '0;
		$display("test gating done");

		reinit(8'h80);
		stop_exec <= 1'b1;
		@(posedge mclk);
		stop_exec <= 1'b0;
		@(negedge mclk);
		chk(ill === 1'b1 && stop_mode === 1'b0, "stop not refused");
		@(posedge mclk);
		reinit(8'h86);
		stop_cycle(1'b1, 1'b0, 8500);
		chk(rst_seen == 0, "watchdog ran in stop");
		reinit(8'h02);
		stop_cycle(1'b0, 1'b0, 10);
		reinit(8'h86);
		stop_cycle(1'b1, 1'b1, 10);
		$display("test stop done");
		end_of_test();
	end
endmodule
